//--- hw/evh_event_handler.sv
// Event handler top: flags, enables, priority code, level summary, interrupt.
// Assumes an Avalon-MM master on the same 25 MHz clock and async sources.
`timescale 1ns/1ps
module evh_event_handler #(
    parameter int N = evh_pkg::EVH_N_SRC
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic [evh_pkg::EVH_ADDR_W-1:0] avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [evh_pkg::EVH_DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic      [evh_pkg::EVH_DATA_W-1:0] avs_readdata,
    output logic                               avs_waitrequest,
    input  wire logic [N-1:0]                  event_sources,
    input  wire logic [1:0]                    port_a_edge_requests,
    output logic                               core_event_level_a,
    output logic                               core_event_level_b,
    output logic                               irq
);
    evh_evt_if #(.N(N)) evt ();

    logic [N-1:0]                   src_all;
    logic [N-1:0]                   pa_map;
    logic [N-1:0]                   event_enable_mask_q;
    logic [N-1:0]                   pending_event_flags_q;
    logic [N-1:0]                   pending_event_flags_d;
    logic [N-1:0]                   set_vec;
    logic [N-1:0]                   clr_vec;
    logic [7:0]                     highest_event_code_q;
    logic                           high_level_pending_q;
    logic                           low_level_pending_q;
    logic [N-1:0]                   irq_status_q;
    logic [N-1:0]                   irq_status_d;
    logic [N-1:0]                   irq_mask_q;
    logic [N-1:0]                   irq_mask_d;
    logic [N-1:0]                   irq_clr_vec;
    logic                           ack_q;
    logic                           req;
    logic                           wr_go;
    logic                           rd_go;
    logic                           lane0;
    logic [evh_pkg::EVH_DATA_W-1:0] rd_mux;
    logic [evh_pkg::EVH_DATA_W-1:0] readdata_q;
    logic                           irq_q;

    // Port A pin requests merge onto their default positions
    always_comb begin
        pa_map                       = '0;
        pa_map[evh_pkg::EVH_PA_POS1] = port_a_edge_requests[1];
        pa_map[evh_pkg::EVH_PA_POS0] = port_a_edge_requests[0];
        src_all                      = event_sources | pa_map;
    end

    evh_sync_edge #(.N(N)) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .src_in  (src_all),
        .evt     (evt.sync)
    );

    evh_prio_enc #(.N(N)) u_prio (
        .evt (evt.prio)
    );

    // Bus handshake: one wait state on every access.
    // Fixed latency keeps the read mux out of the waitrequest path.
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_go           = avs_write & ack_q;
    assign rd_go           = avs_read & ~ack_q;
    assign lane0           = avs_byteenable[0];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Enable mask register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            event_enable_mask_q <= evh_pkg::EVH_RST_ENABLE;
        end else if (wr_go && lane0 && avs_address == evh_pkg::EVH_A_ENABLE) begin
            event_enable_mask_q <= avs_writedata[N-1:0];
        end
    end

    // Pending flags: set beats a coincident clear
    always_comb begin
        set_vec = evt.src_rise & event_enable_mask_q;
        clr_vec = '0;
        if (wr_go && lane0 && avs_address == evh_pkg::EVH_A_FLAGS) begin
            clr_vec = avs_writedata[N-1:0];
        end
        pending_event_flags_d = (pending_event_flags_q & ~clr_vec) | set_vec;
    end

    assign evt.flags_next = pending_event_flags_d;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pending_event_flags_q <= evh_pkg::EVH_RST_FLAGS;
        end else begin
            pending_event_flags_q <= pending_event_flags_d;
        end
    end

    // Code and summary track the flags in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            highest_event_code_q <= evh_pkg::EVH_RST_CODE;
        end else begin
            highest_event_code_q <= evt.next_code;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            high_level_pending_q <= evh_pkg::EVH_RST_SUMMARY[evh_pkg::EVH_SUM_HI_BIT];
            low_level_pending_q  <= evh_pkg::EVH_RST_SUMMARY[evh_pkg::EVH_SUM_LO_BIT];
        end else begin
            high_level_pending_q <= |pending_event_flags_d[evh_pkg::EVH_HI_MSB:evh_pkg::EVH_HI_LSB];
            low_level_pending_q  <= |pending_event_flags_d[evh_pkg::EVH_LO_MSB:evh_pkg::EVH_LO_LSB];
        end
    end

    // Each group drives one core level, held until its flags clear
    assign core_event_level_a = high_level_pending_q;
    assign core_event_level_b = low_level_pending_q;

    // Interrupt status: sticky, write one to clear, new set wins
    always_comb begin
        irq_clr_vec = '0;
        if (wr_go && lane0 && avs_address == evh_pkg::EVH_A_IRQ_STAT) begin
            irq_clr_vec = avs_writedata[N-1:0];
        end
        irq_status_d = (irq_status_q & ~irq_clr_vec) | set_vec;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_status_q <= '0;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    always_comb begin
        irq_mask_d = irq_mask_q;
        if (wr_go && lane0 && avs_address == evh_pkg::EVH_A_IRQ_MASK) begin
            irq_mask_d = avs_writedata[N-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_mask_q <= evh_pkg::EVH_RST_MASK;
        end else begin
            irq_mask_q <= irq_mask_d;
        end
    end

    // Next mask too, so the output never lags a mask write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_d & irq_mask_d);
        end
    end

    assign irq = irq_q;

    // Read mux; unmapped words read zero
    always_comb begin
        rd_mux = '0;
        if (avs_address == evh_pkg::EVH_A_FLAGS) begin
            rd_mux[N-1:0] = pending_event_flags_q;
        end else if (avs_address == evh_pkg::EVH_A_ENABLE) begin
            rd_mux[N-1:0] = event_enable_mask_q;
        end else if (avs_address == evh_pkg::EVH_A_CODE) begin
            rd_mux[7:0] = highest_event_code_q;
        end else if (avs_address == evh_pkg::EVH_A_SUMMARY) begin
            rd_mux[evh_pkg::EVH_SUM_HI_BIT] = high_level_pending_q;
            rd_mux[evh_pkg::EVH_SUM_LO_BIT] = low_level_pending_q;
        end else if (avs_address == evh_pkg::EVH_A_IRQ_STAT) begin
            rd_mux[N-1:0] = irq_status_q;
        end else if (avs_address == evh_pkg::EVH_A_IRQ_MASK) begin
            rd_mux[N-1:0] = irq_mask_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            readdata_q <= '0;
        end else if (rd_go) begin
            readdata_q <= rd_mux;
        end
    end

    assign avs_readdata = readdata_q;

    // Checks
    sequence s_req_wait;
        req && avs_waitrequest;
    endsequence

    sequence s_req_done;
        !avs_waitrequest;
    endsequence

    sequence s_lvl_a_held;
        core_event_level_a ##1 (core_event_level_a || $past(|clr_vec[7:4]));
    endsequence

    sequence s_lvl_b_held;
        core_event_level_b ##1 (core_event_level_b || $past(|clr_vec[3:0]));
    endsequence

    a_bus_one_wait: assert property (@(posedge ref_clk) disable iff (rst)
        s_req_wait |=> s_req_done)
        else $error("access not answered after one wait state");

    a_flag_set_rise: assert property (@(posedge ref_clk) disable iff (rst)
        (|set_vec) |=> ((pending_event_flags_q & $past(set_vec)) == $past(set_vec)))
        else $error("enabled rising edge did not set its flag");

    a_flag_no_spur: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> ((pending_event_flags_q & ~$past(pending_event_flags_q) & ~$past(set_vec)) == '0))
        else $error("flag set without an enabled rising edge");

    a_flag_w1c: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_go && lane0 && avs_address == evh_pkg::EVH_A_FLAGS)
        |=> ((pending_event_flags_q & $past(avs_writedata[N-1:0]) & ~$past(set_vec)) == '0))
        else $error("written one did not clear flag");

    a_flag_keep_zero: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> ((~pending_event_flags_q & $past(pending_event_flags_q) & ~$past(clr_vec)) == '0))
        else $error("flag fell without a write of one");

    a_code_empty_ff: assert property (@(posedge ref_clk) disable iff (rst)
        (pending_event_flags_q == '0) |-> (highest_event_code_q == 8'hFF))
        else $error("code not FF with no pending flag");

    a_code_top_index: assert property (@(posedge ref_clk) disable iff (rst)
        (pending_event_flags_q != '0)
        |-> ((pending_event_flags_q >> highest_event_code_q[2:0]) == 8'h01 && highest_event_code_q[7:3] == '0))
        else $error("code is not the top pending index");

    a_sum_high_bit: assert property (@(posedge ref_clk) disable iff (rst)
        high_level_pending_q == (|pending_event_flags_q[7:4]))
        else $error("high summary bit disagrees with flags");

    a_sum_low_bit: assert property (@(posedge ref_clk) disable iff (rst)
        low_level_pending_q == (|pending_event_flags_q[3:0]))
        else $error("low summary bit disagrees with flags");

    a_core_hold_lvl: assert property (@(posedge ref_clk) disable iff (rst)
        (|set_vec[7:4]) |=> s_lvl_a_held)
        else $error("high core level not raised or held");

    a_core_hold_low: assert property (@(posedge ref_clk) disable iff (rst)
        (|set_vec[3:0]) |=> s_lvl_b_held)
        else $error("low core level not raised or held");

    a_en_gate_off: assert property (@(posedge ref_clk) disable iff (rst)
        (evt.src_rise & ~event_enable_mask_q) != '0
        |=> ((pending_event_flags_q & ~$past(pending_event_flags_q) & $past(~event_enable_mask_q)) == '0))
        else $error("disabled source set a flag");

    a_irq_level_out: assert property (@(posedge ref_clk) disable iff (rst)
        irq == (|(irq_status_q & irq_mask_q)))
        else $error("interrupt output disagrees with status and mask");

    a_en_write_lands: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_go && lane0 && avs_address == evh_pkg::EVH_A_ENABLE)
        |=> (event_enable_mask_q == $past(avs_writedata[N-1:0])))
        else $error("enable write did not land");

    a_be_off_keeps: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_go && !lane0) |=> ($stable(event_enable_mask_q) && $stable(irq_mask_q)))
        else $error("write with lane zero off changed a register");

    a_irq_stat_set: assert property (@(posedge ref_clk) disable iff (rst)
        (|set_vec) |=> ((irq_status_q & $past(set_vec)) == $past(set_vec)))
        else $error("event did not set its interrupt status bit");

    a_irq_stat_w1c: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_go && lane0 && avs_address == evh_pkg::EVH_A_IRQ_STAT)
        |=> ((irq_status_q & $past(avs_writedata[N-1:0]) & ~$past(set_vec)) == '0))
        else $error("written one did not clear interrupt status");

    a_irq_mask_write: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_go && lane0 && avs_address == evh_pkg::EVH_A_IRQ_MASK)
        |=> (irq_mask_q == $past(avs_writedata[N-1:0])))
        else $error("interrupt mask write did not land");

    a_rd_data_fresh: assert property (@(posedge ref_clk) disable iff (rst)
        (avs_read && !avs_waitrequest) |-> (avs_readdata == $past(rd_mux)))
        else $error("read data not captured in the request cycle");

    a_rd_upper_zero: assert property (@(posedge ref_clk) disable iff (rst)
        avs_readdata[evh_pkg::EVH_DATA_W-1:8] == '0)
        else $error("read data upper bits not zero");

    a_sum_rsvd_zero: assert property (@(posedge ref_clk) disable iff (rst)
        (avs_read && !avs_waitrequest && avs_address == evh_pkg::EVH_A_SUMMARY)
        |-> (avs_readdata[evh_pkg::EVH_DATA_W-1:2] == '0))
        else $error("unused summary bits not zero");
endmodule

//--- shared/evh_pkg.sv
// Constants for the event handler: register map, field layout, reset values.
// Assumes a 32-bit Avalon-MM slave port with word addresses and one 25 MHz clock.
package evh_pkg;
    localparam int          EVH_N_SRC       = 8;
    localparam int          EVH_ADDR_W      = 3;
    localparam int          EVH_DATA_W      = 32;
    // Word addresses of the register file
    localparam logic [2:0]  EVH_A_FLAGS     = 3'h0;
    localparam logic [2:0]  EVH_A_ENABLE    = 3'h1;
    localparam logic [2:0]  EVH_A_CODE      = 3'h2;
    localparam logic [2:0]  EVH_A_SUMMARY   = 3'h3;
    localparam logic [2:0]  EVH_A_IRQ_STAT  = 3'h4;
    localparam logic [2:0]  EVH_A_IRQ_MASK  = 3'h5;
    // Field layout
    localparam int          EVH_HI_LSB      = 4;
    localparam int          EVH_HI_MSB      = 7;
    localparam int          EVH_LO_LSB      = 0;
    localparam int          EVH_LO_MSB      = 3;
    localparam int          EVH_SUM_HI_BIT  = 1;
    localparam int          EVH_SUM_LO_BIT  = 0;
    localparam int          EVH_PA_POS1     = 4;
    localparam int          EVH_PA_POS0     = 0;
    // Reset values
    localparam logic [7:0]  EVH_RST_ENABLE  = 8'h00;
    localparam logic [7:0]  EVH_RST_FLAGS   = 8'h00;
    localparam logic [7:0]  EVH_RST_CODE    = 8'hFF;
    localparam logic [7:0]  EVH_NO_EVENT    = 8'hFF;
    localparam logic [1:0]  EVH_RST_SUMMARY = 2'h0;
    localparam logic [7:0]  EVH_RST_MASK    = 8'h00;
    // Timing: sources must hold two clock periods at 25 MHz
    localparam int          EVH_CLK_HZ      = 25000000;
    localparam int          EVH_SYNC_STAGES = 3;
endpackage

//--- shared/evh_evt_if.sv
// Internal carrier between the event handler core and its helpers.
// Assumes all parties share one clock.
`timescale 1ns/1ps
interface evh_evt_if #(
    parameter int N = 8
);
    logic [N-1:0] src_rise;
    logic [N-1:0] flags_next;
    logic [7:0]   next_code;

    modport sync (output src_rise);
    modport prio (input flags_next, output next_code);
    modport core (input src_rise, input next_code, output flags_next);
endinterface

//--- hw/evh_sync_edge.sv
// Three-stage synchroniser and rising edge detector for the event sources.
// Assumes sources are asynchronous and hold at least two clock periods.
`timescale 1ns/1ps
module evh_sync_edge #(
    parameter int N = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [N-1:0] src_in,
    evh_evt_if.sync           evt
);
    logic [N-1:0] s1_q;
    logic [N-1:0] s2_q;
    logic [N-1:0] s3_q;
    logic [N-1:0] level_q;
    logic [N-1:0] rise_q;

    // First stage feeds only the second
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= src_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            level_q <= '0;
            rise_q  <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                rise_q[i] <= 1'b0;
                if (s2_q[i] == s3_q[i] && s2_q[i] != level_q[i]) begin
                    level_q[i] <= s2_q[i];
                    rise_q[i]  <= s2_q[i];
                end
            end
        end
    end

    assign evt.src_rise = rise_q;

    a_rise_one_cycle: assert property (@(posedge ref_clk) disable iff (rst)
        (rise_q & $past(rise_q)) == '0)
        else $error("rise pulse lasted more than one cycle");
endmodule

//--- hw/evh_prio_enc.sv
// Highest pending event encoder.
// Assumes next flag vector from the core; result is registered there.
`timescale 1ns/1ps
module evh_prio_enc #(
    parameter int N = 8
) (
    evh_evt_if.prio evt
);
    logic [7:0] code;

    // Ascending scan so the top index wins
    always_comb begin
        code = evh_pkg::EVH_NO_EVENT;
        for (int i = 0; i < N; i++) begin
            if (evt.flags_next[i]) begin
                code = 8'(i);
            end
        end
    end

    assign evt.next_code = code;
endmodule

//--- tb/evh_src_model.sv
// Model of the event sources and Port A pins that feed the handler.
// Assumes the bench fires one burst at a time on the shared clock.
`timescale 1ns/1ps
module evh_src_model (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       fire,
    input  wire logic [7:0] fire_mask,
    input  wire logic [1:0] pa_mask,
    output logic      [7:0] event_sources,
    output logic      [1:0] port_a_edge_requests
);
    logic [1:0] hold_q;
    // Four clocks high, so the agree filter surely takes it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_q <= 2'h0;
            event_sources <= 8'h00;
            port_a_edge_requests <= 2'h0;
        end else if (fire) begin
            hold_q <= 2'h3;
            event_sources <= fire_mask;
            port_a_edge_requests <= pa_mask;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end else begin
            event_sources <= 8'h00;
            port_a_edge_requests <= 2'h0;
        end
    end
endmodule

//--- tb/evh_event_handler_tb.sv
// Self-checking bench for the event handler, Avalon-MM master and source model.
// Assumes one 25 MHz clock; reads are scored against a queue of expectations.
`timescale 1ns/1ps
module evh_event_handler_tb;
    logic        ref_clk;
    logic        rst;
    logic [2:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  event_sources;
    logic [1:0]  port_a_edge_requests;
    logic        core_event_level_a;
    logic        core_event_level_b;
    logic        irq;
    logic        fire;
    logic [7:0]  fire_mask;
    logic [1:0]  pa_mask;
    logic [7:0]  en;
    logic [7:0]  m;
    logic [31:0] exp_q[$];
    string       nam_q[$];
    int          err_count;
    int          n_tests;
    int          cyc;
    integer      seed;

    evh_event_handler dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .event_sources(event_sources),
        .port_a_edge_requests(port_a_edge_requests), .core_event_level_a(core_event_level_a),
        .core_event_level_b(core_event_level_b), .irq(irq));
    evh_src_model src (.ref_clk(ref_clk), .rst(rst), .fire(fire), .fire_mask(fire_mask), .pa_mask(pa_mask),
        .event_sources(event_sources), .port_a_edge_requests(port_a_edge_requests));

    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Long enough for every scenario with a wide margin
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Read data taken at the accepting edge, pre-edge values
    always @(posedge ref_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            chk(nam_q.pop_front(), exp_q.pop_front(), avs_readdata);
        end
    end

    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        avs_write <= w;
        avs_read <= ~w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        // Request held until waitrequest is seen low at a rising edge
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 4'hF);
    endtask

    task automatic rd(input logic [2:0] a, input logic [31:0] e, input string n);
        exp_q.push_back(e);
        nam_q.push_back(n);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask

    function automatic logic [31:0] top(input logic [7:0] v);
        top = 32'hFF;
        for (int k = 0; k < 8; k++) if (v[k]) top = 32'(k);
    endfunction

    task automatic burst(input logic [7:0] mk, input logic [1:0] p);
        @(posedge ref_clk);
        fire <= 1'b1;
        fire_mask <= mk;
        pa_mask <= p;
        @(posedge ref_clk);
        fire <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic look(input logic [7:0] v);
        rd(evh_pkg::EVH_A_FLAGS, {24'h0, v}, "flags");
        rd(evh_pkg::EVH_A_CODE, top(v), "code");
        rd(evh_pkg::EVH_A_SUMMARY, {30'h0, |v[7:4], |v[3:0]}, "summary");
        chk("level_a", {31'h0, |v[7:4]}, {31'h0, core_event_level_a});
        chk("level_b", {31'h0, |v[3:0]}, {31'h0, core_event_level_b});
    endtask

    initial begin
        rst = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
        {fire, fire_mask, pa_mask, err_count, n_tests, cyc} = '0;
        seed = 32'h12EF;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        look(8'h00);
        rd(evh_pkg::EVH_A_ENABLE, 32'h0, "enable");
        rd(evh_pkg::EVH_A_IRQ_MASK, 32'h0, "irq_mask");
        $display("reset values done");
        en = 8'($random(seed));
        wr(evh_pkg::EVH_A_ENABLE, en);
        rd(evh_pkg::EVH_A_ENABLE, {24'h0, en}, "enable");
        for (int i = 0; i < 8; i++) begin
            wr(evh_pkg::EVH_A_ENABLE, 8'hFF);
            burst(8'h01 << i, 2'h0);
            look(8'h01 << i);
            wr(evh_pkg::EVH_A_FLAGS, ~(8'h01 << i));
            look(8'h01 << i);
            wr(evh_pkg::EVH_A_FLAGS, 8'h01 << i);
            look(8'h00);
        end
        $display("single sources done");
        for (int i = 0; i < 4; i++) begin
            en = 8'($random(seed));
            m = 8'($random(seed));
            wr(evh_pkg::EVH_A_ENABLE, en);
            burst(m, 2'h0);
            look(m & en);
            wr(evh_pkg::EVH_A_FLAGS, 8'hFF);
        end
        look(8'h00);
        $display("random masks done");
        wr(evh_pkg::EVH_A_ENABLE, 8'h11);
        burst(8'h00, 2'h3);
        look(8'h11);
        wr(evh_pkg::EVH_A_FLAGS, 8'hFF);
        wr(evh_pkg::EVH_A_ENABLE, 8'h10);
        burst(8'h00, 2'h3);
        look(8'h10);
        wr(evh_pkg::EVH_A_FLAGS, 8'hFF);
        $display("port a done");
        wr(evh_pkg::EVH_A_IRQ_STAT, 8'hFF);
        rd(evh_pkg::EVH_A_IRQ_STAT, 32'h0, "irq_stat");
        wr(evh_pkg::EVH_A_ENABLE, 8'hFF);
        burst(8'h04, 2'h0);
        rd(evh_pkg::EVH_A_IRQ_STAT, 32'h4, "irq_stat");
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(evh_pkg::EVH_A_IRQ_MASK, 8'h04);
        repeat (3) @(posedge ref_clk);
        chk("irq_open", 32'h1, {31'h0, irq});
        wr(evh_pkg::EVH_A_IRQ_STAT, 8'h04);
        repeat (3) @(posedge ref_clk);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        $display("interrupt done");
        bus(1'b1, evh_pkg::EVH_A_ENABLE, 32'h5A, 4'h0);
        rd(evh_pkg::EVH_A_ENABLE, 32'hFF, "enable_be0");
        wr(3'h6, 8'hFF);
        rd(3'h6, 32'h0, "unmapped");
        $display("refusals done");
        burst(8'h81, 2'h0);
        look(8'h85);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        look(8'h00);
        rd(evh_pkg::EVH_A_ENABLE, 32'h0, "enable_rst");
        $display("mid-run reset done");
        repeat (4) @(posedge ref_clk);
        results();
    end
endmodule
